/* verilog/sfb_core.sv */
// status flags register and banked data memory of the core
//
// The implementer's own choices: the address map and the plain strobed port.
`include "sfb_params.svh"

module sfb_core (
    input  wire logic               i_clock,
    input  wire logic               i_rstn,
    input  wire logic               i_clock_en,
    input  wire logic [11:0]        i_addr,
    input  wire logic               i_linear,
    input  wire logic [7:0]         i_wdata,
    input  wire logic               i_wr,
    input  wire logic               i_rd,
    input  wire sfb_pkg::sfb_exec_t i_exec,
    input  wire logic               i_watchdog_clear_instr,
    input  wire logic               i_sleep_instr,
    input  wire logic               i_watchdog_timer_timeout,
    input  wire logic               i_warm_reset,
    input  wire logic               i_warm_reset_watchdog,
    output logic [7:0]              o_rdata,
    output logic [7:0]              o_status,
    output logic [7:0]              o_exec_result,
    output logic                    o_irq
);
    sfb_pkg::sfb_state_t   state_reg;
    sfb_pkg::sfb_state_t   state_next;
    sfb_pkg::sfb_decode_t  bus_dec;
    sfb_pkg::sfb_decode_t  exec_dec;
    sfb_pkg::sfb_alu_out_t alu_out;

    logic [`SFB_IRQ_W-1:0] events;
    logic [7:0]            read_value;
    logic                  exec_hits_status;
    logic                  bus_write;

    sfb_addr_map u_bus_map (
        .i_addr   (i_addr),
        .i_linear (i_linear),
        .o_dec    (bus_dec)
    );

    // datapath results go to banked addresses only
    sfb_addr_map u_exec_map (
        .i_addr   (i_exec.addr),
        .i_linear (1'b0),
        .o_dec    (exec_dec)
    );

    sfb_flag_alu u_alu (
        .i_op  (i_exec.op),
        .i_a   (i_exec.a),
        .i_b   (i_exec.b),
        .o_out (alu_out)
    );

    function automatic logic [7:0] status_byte(input logic [4:0] flags);
        return {3'h0, flags};
    endfunction

    always_comb begin
        state_next       = state_reg;
        events           = '0;
        read_value       = 8'h00;
        exec_hits_status = i_exec.valid && i_exec.to_file &&
                           (exec_dec.region == sfb_pkg::SFB_RGN_STATUS);
        // an executing instruction that writes the file owns the write port for its cycle
        bus_write        = i_wr && !(i_exec.valid && i_exec.to_file);

        // read path: data stand in the cycle after the strobe only
        if (bus_dec.region == sfb_pkg::SFB_RGN_STATUS) begin
            read_value = status_byte(state_reg.status);
        end else if (bus_dec.region == sfb_pkg::SFB_RGN_GENRAM) begin
            read_value = state_reg.genram[bus_dec.index];
        end else if (bus_dec.region == sfb_pkg::SFB_RGN_COMMON) begin
            read_value = state_reg.common[bus_dec.index[3:0]];
        end else if (bus_dec.region == sfb_pkg::SFB_RGN_IRQ_STAT) begin
            read_value = {5'h00, state_reg.irq_stat};
        end else if (bus_dec.region == sfb_pkg::SFB_RGN_IRQ_MASK) begin
            read_value = {5'h00, state_reg.irq_mask};
        end else begin
            read_value = 8'h00;
        end
        state_next.rdata = i_rd ? read_value : 8'h00;

        // software writes over the register port
        if (bus_write) begin
            if (bus_dec.region == sfb_pkg::SFB_RGN_STATUS) begin
                // only the result flags take the data; cause flags and top bits ignore it
                state_next.status[`SFB_Z_BIT]  = i_wdata[`SFB_Z_BIT];
                state_next.status[`SFB_DIGIT_CARRY_BIT] = i_wdata[`SFB_DIGIT_CARRY_BIT];
                state_next.status[`SFB_C_BIT]  = i_wdata[`SFB_C_BIT];
            end else if (bus_dec.region == sfb_pkg::SFB_RGN_GENRAM) begin
                state_next.genram[bus_dec.index] = i_wdata;
            end else if (bus_dec.region == sfb_pkg::SFB_RGN_COMMON) begin
                state_next.common[bus_dec.index[3:0]] = i_wdata;
            end else if (bus_dec.region == sfb_pkg::SFB_RGN_IRQ_STAT) begin
                state_next.irq_stat = state_reg.irq_stat & ~i_wdata[`SFB_IRQ_W-1:0];
            end else if (bus_dec.region == sfb_pkg::SFB_RGN_IRQ_MASK) begin
                state_next.irq_mask = i_wdata[`SFB_IRQ_W-1:0];
            end
        end

        // instruction datapath
        if (i_exec.valid) begin
            state_next.result = alu_out.result;
            if (i_exec.to_file) begin
                if (exec_hits_status) begin
                    // result is dropped; flags come from the flag logic below
                    events[`SFB_EV_BLOCK_BIT] = 1'b1;
                end else if (exec_dec.region == sfb_pkg::SFB_RGN_GENRAM) begin
                    state_next.genram[exec_dec.index] = alu_out.result;
                end else if (exec_dec.region == sfb_pkg::SFB_RGN_COMMON) begin
                    state_next.common[exec_dec.index[3:0]] = alu_out.result;
                end
            end
            state_next.status[`SFB_Z_BIT] = alu_out.z;
            if (alu_out.affects_carry) begin
                state_next.status[`SFB_DIGIT_CARRY_BIT] = alu_out.digit_carry;
                state_next.status[`SFB_C_BIT]  = alu_out.c;
            end
        end

        // reset-cause flags
        if (i_watchdog_clear_instr) begin
            state_next.status[`SFB_TIMEOUT_BIT]   = 1'b1;
            state_next.status[`SFB_POWERDOWN_BIT] = 1'b1;
        end
        if (i_sleep_instr) begin
            state_next.status[`SFB_TIMEOUT_BIT]   = 1'b1;
            state_next.status[`SFB_POWERDOWN_BIT] = 1'b0;
            events[`SFB_EV_SLEEP_BIT]             = 1'b1;
        end
        // a time-out beats a same-cycle clear or sleep
        if (i_watchdog_timer_timeout) begin
            state_next.status[`SFB_TIMEOUT_BIT] = 1'b0;
            events[`SFB_EV_TIMEOUT_BIT]         = 1'b1;
        end

        // warm reset: result flags kept, cause flags by reset source
        if (i_warm_reset) begin
            state_next.status[`SFB_Z_BIT]  = state_reg.status[`SFB_Z_BIT];
            state_next.status[`SFB_DIGIT_CARRY_BIT] = state_reg.status[`SFB_DIGIT_CARRY_BIT];
            state_next.status[`SFB_C_BIT]  = state_reg.status[`SFB_C_BIT];
            if (i_warm_reset_watchdog) begin
                state_next.status[`SFB_TIMEOUT_BIT]   = 1'b0;
                state_next.status[`SFB_POWERDOWN_BIT] = 1'b1;
            end else begin
                state_next.status[`SFB_TIMEOUT_BIT]   = state_reg.status[`SFB_TIMEOUT_BIT];
                state_next.status[`SFB_POWERDOWN_BIT] = state_reg.status[`SFB_POWERDOWN_BIT];
            end
        end

        // sticky events: a set in the clearing cycle survives
        state_next.irq_stat = state_next.irq_stat | events;
        state_next.irq      = |(state_next.irq_stat & state_next.irq_mask);
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            state_reg          <= '0;
            state_reg.status   <= `SFB_STATUS_RESET;
        end else if (i_clock_en) begin
            state_reg <= state_next;
        end
    end

    assign o_rdata       = state_reg.rdata;
    assign o_status      = status_byte(state_reg.status);
    assign o_exec_result = state_reg.result;
    assign o_irq         = state_reg.irq;
endmodule

/* verilog/sfb_params.svh */
// offsets, field positions, reset values and sizes of the status and bank map block
`ifndef SFB_PARAMS_SVH
`define SFB_PARAMS_SVH

`define SFB_ADDR_W          12
`define SFB_LOC_W           7
`define SFB_BANK_W          5
`define SFB_STATUS_LOC      7'h03
`define SFB_PERIPH_FIRST    7'h0C
`define SFB_PERIPH_LAST     7'h1F
`define SFB_GENRAM_FIRST    7'h20
`define SFB_GENRAM_LAST     7'h6F
`define SFB_COMMON_FIRST    7'h70
`define SFB_GENRAM_PER_BANK 80
`define SFB_GENRAM_BANKS    8
`define SFB_GENRAM_BYTES    640
`define SFB_COMMON_BYTES    16
`define SFB_INDEX_W         10
`define SFB_IRQ_BANK        5'h1F
`define SFB_IRQ_STAT_LOC    7'h0C
`define SFB_IRQ_MASK_LOC    7'h0D
`define SFB_TIMEOUT_BIT     4
`define SFB_POWERDOWN_BIT   3
`define SFB_Z_BIT           2
`define SFB_DIGIT_CARRY_BIT 1
`define SFB_C_BIT           0
`define SFB_STATUS_RESET    5'h18
`define SFB_IRQ_W           3
`define SFB_EV_TIMEOUT_BIT  0
`define SFB_EV_SLEEP_BIT    1
`define SFB_EV_BLOCK_BIT    2

`endif

/* verilog/sfb_pkg.sv */
// types shared by the status and bank map block
`include "sfb_params.svh"

package sfb_pkg;

    typedef enum logic [2:0] {
        SFB_OP_ADD  = 3'h0,
        SFB_OP_SUB  = 3'h1,
        SFB_OP_AND  = 3'h2,
        SFB_OP_OR   = 3'h3,
        SFB_OP_XOR  = 3'h4,
        SFB_OP_PASS = 3'h5
    } sfb_op_t;

    typedef enum logic [2:0] {
        SFB_RGN_UNIMPL   = 3'h0,
        SFB_RGN_STATUS   = 3'h1,
        SFB_RGN_PERIPH   = 3'h2,
        SFB_RGN_GENRAM   = 3'h3,
        SFB_RGN_COMMON   = 3'h4,
        SFB_RGN_IRQ_STAT = 3'h5,
        SFB_RGN_IRQ_MASK = 3'h6
    } sfb_region_t;

    typedef struct packed {
        logic       valid;
        sfb_op_t    op;
        logic [7:0] a;
        logic [7:0] b;
        logic       to_file;
        logic [11:0] addr;
    } sfb_exec_t;

    typedef struct packed {
        logic [7:0] result;
        logic       affects_carry;
        logic       z;
        logic       digit_carry;
        logic       c;
    } sfb_alu_out_t;

    typedef struct packed {
        sfb_region_t region;
        logic [9:0]  index;
    } sfb_decode_t;

    typedef struct packed {
        logic [4:0]       status;
        logic [2:0]       irq_stat;
        logic [2:0]       irq_mask;
        logic             irq;
        logic [7:0]       rdata;
        logic [7:0]       result;
        logic [639:0][7:0] genram;
        logic [15:0][7:0] common;
    } sfb_state_t;

endpackage

/* verilog/sfb_flag_alu.sv */
// result and flag generator for the arithmetic and logic operations
`include "sfb_params.svh"

module sfb_flag_alu (
    input  wire sfb_pkg::sfb_op_t      i_op,
    input  wire logic [7:0]            i_a,
    input  wire logic [7:0]            i_b,
    output sfb_pkg::sfb_alu_out_t      o_out
);
    logic [7:0] addend;
    logic       carry_in;
    logic [4:0] low_sum;
    logic [8:0] full_sum;

    always_comb begin
        // subtraction adds the two's complement of b, so carries are inverted borrows
        addend   = (i_op == sfb_pkg::SFB_OP_SUB) ? ~i_b : i_b;
        carry_in = (i_op == sfb_pkg::SFB_OP_SUB);
        low_sum  = {1'b0, i_a[3:0]} + {1'b0, addend[3:0]} + {4'h0, carry_in};
        full_sum = {1'b0, i_a} + {1'b0, addend} + {8'h00, carry_in};
        o_out.affects_carry = 1'b0;
        case (i_op)
            sfb_pkg::SFB_OP_ADD,
            sfb_pkg::SFB_OP_SUB: begin
                o_out.result        = full_sum[7:0];
                o_out.affects_carry = 1'b1;
            end
            sfb_pkg::SFB_OP_AND:  o_out.result = i_a & i_b;
            sfb_pkg::SFB_OP_OR:   o_out.result = i_a | i_b;
            sfb_pkg::SFB_OP_XOR:  o_out.result = i_a ^ i_b;
            default:              o_out.result = i_a;
        endcase
        o_out.z           = (o_out.result == 8'h00);
        o_out.digit_carry = low_sum[4];
        o_out.c           = full_sum[8];
    end
endmodule

/* verilog/sfb_addr_map.sv */
// data address decoder: banked and linear views of the data memory
`include "sfb_params.svh"

module sfb_addr_map (
    input  wire logic [11:0]           i_addr,
    input  wire logic                  i_linear,
    output sfb_pkg::sfb_decode_t       o_dec
);
    function automatic sfb_pkg::sfb_decode_t decode(input logic [11:0] addr, input logic linear);
        sfb_pkg::sfb_decode_t d;
        logic [4:0] bank;
        logic [6:0] loc;
        logic [9:0] genram_off;
        d.region   = sfb_pkg::SFB_RGN_UNIMPL;
        d.index    = 10'h000;
        bank       = addr[11:7];
        loc        = addr[6:0];
        genram_off = 10'({3'h0, loc} - {3'h0, `SFB_GENRAM_FIRST});
        if (linear) begin
            // all banks' general RAM as one run
            if (addr < 12'(`SFB_GENRAM_BYTES)) begin
                d.region = sfb_pkg::SFB_RGN_GENRAM;
                d.index  = addr[9:0];
            end
        end else if (loc == `SFB_STATUS_LOC) begin
            d.region = sfb_pkg::SFB_RGN_STATUS;
        end else if (bank == `SFB_IRQ_BANK && loc == `SFB_IRQ_STAT_LOC) begin
            d.region = sfb_pkg::SFB_RGN_IRQ_STAT;
        end else if (bank == `SFB_IRQ_BANK && loc == `SFB_IRQ_MASK_LOC) begin
            d.region = sfb_pkg::SFB_RGN_IRQ_MASK;
        end else if (loc >= `SFB_PERIPH_FIRST && loc <= `SFB_PERIPH_LAST) begin
            d.region = sfb_pkg::SFB_RGN_PERIPH;
        end else if (loc >= `SFB_GENRAM_FIRST && loc <= `SFB_GENRAM_LAST) begin
            if (bank < 5'(`SFB_GENRAM_BANKS)) begin
                d.region = sfb_pkg::SFB_RGN_GENRAM;
                d.index  = 10'(bank * 10'(`SFB_GENRAM_PER_BANK)) + genram_off;
            end
        end else if (loc >= `SFB_COMMON_FIRST) begin
            d.region = sfb_pkg::SFB_RGN_COMMON;
            d.index  = {6'h00, loc[3:0]};
        end
        return d;
    endfunction

    assign o_dec = decode(i_addr, i_linear);
endmodule

/* tb/sfb_core_props.sv */
// concurrent checks on the ports of the status and bank map core
module sfb_core_props (
    input wire logic               i_clock,
    input wire logic               i_rstn,
    input wire logic               i_clock_en,
    input wire logic [11:0]        i_addr,
    input wire logic               i_linear,
    input wire logic               i_wr,
    input wire logic               i_rd,
    input wire sfb_pkg::sfb_exec_t i_exec,
    input wire logic               i_watchdog_clear_instr,
    input wire logic               i_sleep_instr,
    input wire logic               i_watchdog_timer_timeout,
    input wire logic               i_warm_reset,
    input wire logic [7:0]         o_rdata,
    input wire logic [7:0]         o_status,
    input wire logic [7:0]         o_exec_result,
    input wire logic               o_irq
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rstn);
    logic       is_sub;
    logic [7:0] b_op;
    logic [8:0] sum_full;
    logic [4:0] sum_low;
    logic [7:0] res;
    logic       take;
    logic       evq;
    always_comb begin
        is_sub   = (i_exec.op == sfb_pkg::SFB_OP_SUB);
        b_op     = is_sub ? ~i_exec.b : i_exec.b;
        sum_full = {1'b0, i_exec.a} + {1'b0, b_op} + {8'h00, is_sub};
        sum_low  = {1'b0, i_exec.a[3:0]} + {1'b0, b_op[3:0]} + {4'h0, is_sub};
        case (i_exec.op)
            sfb_pkg::SFB_OP_AND:  res = i_exec.a & i_exec.b;
            sfb_pkg::SFB_OP_OR:   res = i_exec.a | i_exec.b;
            sfb_pkg::SFB_OP_XOR:  res = i_exec.a ^ i_exec.b;
            sfb_pkg::SFB_OP_PASS: res = i_exec.a;
            default:              res = sum_full[7:0];
        endcase
        take = i_clock_en && i_exec.valid && !i_wr && !i_warm_reset;
        evq  = i_clock_en && !i_warm_reset;
    end
    sequence s_status_read;
        i_clock_en && i_rd && !i_linear && i_addr[6:0] == 7'h03;
    endsequence
    sequence s_dead_read;
        i_clock_en && i_rd && !i_linear && i_addr[11:7] != 5'h1F
            && (i_addr[6:0] < 7'h03 || i_addr[6:0] inside {[7'h0C:7'h1F]});
    endsequence
    a_upper_bits_zero: assert property (o_status[7:5] == 3'h0)
        else $error("upper status bits not zero");
    a_power_reset_values: assert property ($rose(i_rstn) |-> o_status == 8'h18 && !o_irq)
        else $error("wrong status after power reset");
    a_timeout_clears_flag: assert property (evq && i_watchdog_timer_timeout |=> !o_status[4])
        else $error("time-out flag not cleared");
    a_sleep_marks_flags: assert property (evq && i_sleep_instr && !i_watchdog_timer_timeout
        && !i_watchdog_clear_instr |=> o_status[4:3] == 2'b10) else $error("sleep flags wrong");
    a_clear_sets_flags: assert property (evq && i_watchdog_clear_instr && !i_sleep_instr
        && !i_watchdog_timer_timeout |=> o_status[4:3] == 2'b11) else $error("clear flags wrong");
    a_zero_flag_follows: assert property (take |=> o_status[2] == ($past(res) == 8'h00))
        else $error("zero flag wrong");
    a_carry_flags_match: assert property (take && i_exec.op <= sfb_pkg::SFB_OP_SUB
        |=> o_status[1:0] == $past({sum_low[4], sum_full[8]})) else $error("carry flags wrong");
    a_result_value: assert property (take && !i_exec.to_file |=> o_exec_result == $past(res))
        else $error("operation result wrong");
    a_warm_keeps_flags: assert property (i_clock_en && i_warm_reset && !i_wr
        |=> $stable(o_status[2:0])) else $error("warm reset changed result flags");
    a_status_read_back: assert property (s_status_read |=> o_rdata == $past(o_status))
        else $error("status read wrong");
    a_dead_reads_zero: assert property (s_dead_read |=> o_rdata == 8'h00)
        else $error("unimplemented read not zero");
endmodule

bind sfb_core sfb_core_props chk (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_clock_en(i_clock_en), .i_addr(i_addr), .i_linear(i_linear),
    .i_wr(i_wr), .i_rd(i_rd), .i_exec(i_exec), .i_watchdog_clear_instr(i_watchdog_clear_instr),
    .i_sleep_instr(i_sleep_instr), .i_watchdog_timer_timeout(i_watchdog_timer_timeout),
    .i_warm_reset(i_warm_reset), .o_rdata(o_rdata), .o_status(o_status), .o_exec_result(o_exec_result),
    .o_irq(o_irq)
);

/* tb/status_flags_bank_map_test.sv */
// self-checking bench for the status flags and bank map core
module status_flags_bank_map_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic               i_clock;
    logic               i_rstn;
    logic               i_clock_en;
    logic [11:0]        i_addr;
    logic               i_linear;
    logic [7:0]         i_wdata;
    logic               i_wr;
    logic               i_rd;
    sfb_pkg::sfb_exec_t i_exec;
    logic               i_watchdog_clear_instr;
    logic               i_sleep_instr;
    logic               i_watchdog_timer_timeout;
    logic               i_warm_reset;
    logic               i_warm_reset_watchdog;
    logic [7:0]         o_rdata;
    logic [7:0]         o_status;
    logic [7:0]         o_exec_result;
    logic               o_irq;
    logic [4:0]         evs;
    int                 err_total;
    int                 comparisons;
    int                 cycles;
    assign {i_warm_reset_watchdog, i_warm_reset, i_watchdog_timer_timeout, i_sleep_instr, i_watchdog_clear_instr} = evs;
    sfb_core uut (
        .i_clock(i_clock), .i_rstn(i_rstn), .i_clock_en(i_clock_en), .i_addr(i_addr), .i_linear(i_linear),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_exec(i_exec),
        .i_watchdog_clear_instr(i_watchdog_clear_instr), .i_sleep_instr(i_sleep_instr),
        .i_watchdog_timer_timeout(i_watchdog_timer_timeout), .i_warm_reset(i_warm_reset),
        .i_warm_reset_watchdog(i_warm_reset_watchdog), .o_rdata(o_rdata), .o_status(o_status),
        .o_exec_result(o_exec_result), .o_irq(o_irq)
    );
    always #5 i_clock = ~i_clock;
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge i_clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_total++;
            conclude();
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // one register cycle; a read is judged in the cycle after it
    task automatic bus(input logic w, input logic [11:0] a, input logic lin, input logic [7:0] d,
                       input logic [7:0] e);
        @(posedge i_clock);
        i_addr   <= a;
        i_linear <= lin;
        i_wdata  <= d;
        i_wr     <= w;
        i_rd     <= !w;
        @(posedge i_clock);
        i_wr <= 1'b0;
        i_rd <= 1'b0;
        #1;
        if (!w) check(o_rdata, e);
    endtask
    task automatic ex(input logic [2:0] op, input logic [7:0] a, input logic [7:0] b, input logic tf,
                      input logic [11:0] ad);
        @(posedge i_clock);
        i_exec <= '{1'b1, sfb_pkg::sfb_op_t'(op), a, b, tf, ad};
        @(posedge i_clock);
        i_exec.valid <= 1'b0;
        #1;
    endtask
    task automatic ev(input logic [4:0] v, input logic [7:0] e);
        @(posedge i_clock);
        evs <= v;
        @(posedge i_clock);
        evs <= 5'h00;
        #1;
        check(o_status, e);
    endtask
    task automatic irq_after(input logic e);
        @(posedge i_clock);
        #1;
        check({7'h00, o_irq}, {7'h00, e});
    endtask
    task automatic t_power_reset();
        @(posedge i_clock);
        i_rstn <= 1'b0;
        repeat (10) @(posedge i_clock);
        check(o_status, 8'h18);
        i_rstn <= 1'b1;
        bus(0, 12'h003, 0, 8'h00, 8'h18);
        bus(0, 12'h020, 0, 8'h00, 8'h00);
        $display("power reset test done");
    endtask
    task automatic t_alu();
        logic [2:0] ops [10] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h5};
        logic [7:0] av [10] = '{8'h0F, 8'hFF, 8'h05, 8'h03, 8'h10, 8'hF0, 8'hF0, 8'hAA, 8'h00, 8'h80};
        logic [7:0] bv [10] = '{8'h01, 8'h01, 8'h05, 8'h05, 8'h01, 8'h0F, 8'h0F, 8'hAA, 8'h33, 8'h00};
        logic [7:0] rv [10] = '{8'h10, 8'h00, 8'h00, 8'hFE, 8'h0F, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h80};
        logic [2:0] fv [10] = '{3'h2, 3'h7, 3'h7, 3'h0, 3'h1, 3'h5, 3'h1, 3'h5, 3'h5, 3'h1};
        for (int i = 0; i < 10; i++) begin
            ex(ops[i], av[i], bv[i], 1'b0, 12'h000);
            check(o_exec_result, rv[i]);
            check(o_status, {5'h03, fv[i]});
        end
        $display("alu test done");
    endtask
    task automatic t_events();
        ev(5'b00010, 8'h11);
        ev(5'b00100, 8'h01);
        ev(5'b00001, 8'h19);
        ev(5'b00110, 8'h01);
        ev(5'b11000, 8'h09);
        ev(5'b00001, 8'h19);
        ev(5'b01000, 8'h19);
        $display("event test done");
    endtask
    task automatic t_irq();
        bus(1, 12'hF8C, 0, 8'h07, 8'h00);
        bus(0, 12'hF8C, 0, 8'h00, 8'h00);
        bus(0, 12'hF8D, 0, 8'h00, 8'h00);
        ev(5'b00100, 8'h09);
        bus(0, 12'hF8C, 0, 8'h00, 8'h01);
        irq_after(1'b0);
        bus(1, 12'hF8D, 0, 8'h01, 8'h00);
        irq_after(1'b1);
        bus(1, 12'hF8C, 0, 8'h01, 8'h00);
        irq_after(1'b0);
        ev(5'b00010, 8'h11);
        bus(0, 12'hF8C, 0, 8'h00, 8'h02);
        irq_after(1'b0);
        $display("interrupt test done");
    endtask
    task automatic t_status_write();
        bus(1, 12'h003, 0, 8'hE2, 8'h00);
        bus(0, 12'h003, 0, 8'h00, 8'h12);
        ex(3'h5, 8'h05, 8'h00, 1'b1, 12'h183);
        check(o_status, 8'h12);
        bus(0, 12'hF8C, 0, 8'h00, 8'h06);
        @(posedge i_clock);
        i_clock_en <= 1'b0;
        ex(3'h0, 8'hFF, 8'h01, 1'b0, 12'h000);
        check(o_status, 8'h12);
        @(posedge i_clock);
        i_clock_en <= 1'b1;
        $display("status write test done");
    endtask
    task automatic t_memory();
        bus(1, 12'h020, 0, 8'hA1, 8'h00);
        bus(1, 12'h3EF, 0, 8'hB2, 8'h00);
        bus(0, 12'h000, 1, 8'h00, 8'hA1);
        bus(0, 12'h27F, 1, 8'h00, 8'hB2);
        bus(1, 12'h050, 1, 8'hC3, 8'h00);
        bus(0, 12'h0A0, 0, 8'h00, 8'hC3);
        bus(1, 12'h07F, 0, 8'h5A, 8'h00);
        bus(0, 12'hFFF, 0, 8'h00, 8'h5A);
        bus(1, 12'h2F0, 0, 8'h6B, 8'h00);
        bus(0, 12'h070, 0, 8'h00, 8'h6B);
        bus(1, 12'h00C, 0, 8'hFF, 8'h00);
        bus(0, 12'h00C, 0, 8'h00, 8'h00);
        bus(0, 12'h09F, 0, 8'h00, 8'h00);
        bus(1, 12'h420, 0, 8'h77, 8'h00);
        bus(0, 12'h420, 0, 8'h00, 8'h00);
        bus(0, 12'h000, 0, 8'h00, 8'h00);
        ex(3'h0, 8'h01, 8'h02, 1'b1, 12'h021);
        bus(0, 12'h021, 0, 8'h00, 8'h03);
        $display("memory test done");
    endtask
    initial begin
        i_clock    = 1'b0;
        i_rstn     = 1'b0;
        i_clock_en = 1'b1;
        i_addr     = 12'h000;
        i_linear   = 1'b0;
        i_wdata    = 8'h00;
        i_wr       = 1'b0;
        i_rd       = 1'b0;
        i_exec     = '0;
        evs        = 5'h00;
        t_power_reset();
        t_alu();
        t_events();
        t_irq();
        t_status_write();
        t_memory();
        t_power_reset();
        conclude();
    end
endmodule
